// file: inc/mccr_pkg.sv
// constants shared by the mapper common control register group
package mccr_pkg;
  // register offsets on the processor port
  localparam logic [10:0] ADDR_TEST_LO  = 11'h005;
  localparam logic [10:0] ADDR_OFFS_LO  = 11'h006;
  localparam logic [10:0] ADDR_REPROG   = 11'h007;
  localparam logic [10:0] ADDR_TEST_HI  = 11'h008;
  localparam logic [10:0] ADDR_IRAM_DAT = 11'h00C;
  localparam logic [10:0] ADDR_FMT_CTRL = 11'h010;
  // bit positions in the reprogram control register
  localparam int REPROG_BIT   = 7;
  localparam int OFFS_HI_MSB  = 2;
  // bit positions in the format and bus control register
  localparam int FMT_HI_BIT   = 7;
  localparam int FMT_LO_BIT   = 6;
  localparam int A_TRI_BIT    = 5;
  localparam int B_TRI_BIT    = 4;
  localparam int BLOCK_BIT    = 3;
  localparam int NPI_MSB      = 2;
  // values after reset
  localparam logic [7:0] TEST_RST     = 8'h00;
  localparam logic [7:0] OFFS_LO_RST  = 8'h00;
  localparam logic [7:0] REPROG_RST   = 8'h00;
  localparam logic [7:0] FMT_CTRL_RST = 8'h30;
  localparam logic [7:0] RDATA_RST    = 8'h00;
  // format field codes
  localparam logic [1:0] FMT_STS1 = 2'h0;
  localparam logic [1:0] FMT_STS3 = 2'h1;
  localparam logic [1:0] FMT_AU3  = 2'h2;
  localparam logic [1:0] FMT_TUG3 = 2'h3;
  // null pointer indicator bytes, in column order
  localparam logic [7:0] NPI_BYTE0 = 8'h93;
  localparam logic [7:0] NPI_BYTE1 = 8'hE0;
  localparam logic [7:0] NPI_BYTE2 = 8'h00;
  localparam logic [1:0] NPI_LAST  = 2'h2;
  // loss of transmit clock detection window
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOC_TIME_NS   = 1000;
  localparam int LOC_CYCLES    = LOC_TIME_NS / CLK_PERIOD_NS;
  localparam int LOC_CNT_W     = 6;
  // bip block error sizes
  localparam logic [1:0] BIP_PAIR = 2'h2;
endpackage

// file: sim/mccr_bus_model.sv
// far-side bus timing model: transmit clocks and payload bytes
`timescale 1ns/1ps
module mccr_bus_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] run,    // clock enables, bit0 add, bit1 drop
  output logic      [1:0] tx_clk, // add and drop transmit clocks
  output logic      [7:0] a_data, // a-side payload byte
  output logic      [7:0] b_data  // b-side payload byte
);
  logic [1:0] div_r;              // divider, slow so sampling never aliases
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= 2'h0;
      tx_clk <= 2'h0;
      a_data <= 8'h00;
      b_data <= 8'hA5;
    end else begin
      if (div_r == 2'h2) begin
        div_r  <= 2'h0;
        tx_clk <= tx_clk ^ run;   // a stopped clock holds its level
      end else begin
        div_r <= div_r + 2'h1;
      end
      a_data <= a_data + 8'h01;   // payload changes every byte
      b_data <= a_data ^ 8'h5A;   // b differs so swaps show up
    end
  end
endmodule

// file: sim/mccr_top_tb.sv
// self-checking bench for the common control register group
`timescale 1ns/1ps
module mccr_top_tb;
  logic        clk, rst_n, soft_rst, wr_en, rd_en, iram_sw_en, iram_wr, tx_loc;
  logic [10:0] addr, iram_addr;
  logic [7:0]  wdata, rdata, iram_wdata, iram_rdata, a_add_in, b_add_in;
  logic [7:0]  a_add_out, b_add_out, v;
  logic [1:0]  format_sel, npi_tug, npi_byte, bip_path_errs, bip_tc_errs, run, tx_clk;
  logic        bts, npi_slot_valid, a_add_oe, b_add_oe, bip_valid, last_iwr;
  logic [15:0] bip_path_cnt, bip_tc_cnt;
  int          bad_count, total_checks, cyc;
  logic [7:0]  npi_exp [3];       // indicator bytes in column order

  mccr_top #(.CNT_W(16)) i_mccr_top (
    .clk(clk), .rst_n(rst_n), .soft_rst(soft_rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .iram_sw_en(iram_sw_en), .iram_addr(iram_addr), .iram_wr(iram_wr),
    .iram_wdata(iram_wdata), .iram_rdata(iram_rdata), .format_sel(format_sel), .bus_timing_select(bts),
    .tx_clk_add(tx_clk[0]), .tx_clk_drop(tx_clk[1]), .tx_loc(tx_loc), .npi_slot_valid(npi_slot_valid),
    .npi_tug(npi_tug), .npi_byte(npi_byte), .a_add_in(a_add_in), .b_add_in(b_add_in),
    .a_add_out(a_add_out), .a_add_oe(a_add_oe), .b_add_out(b_add_out), .b_add_oe(b_add_oe),
    .bip_valid(bip_valid), .bip_path_errs(bip_path_errs), .bip_tc_errs(bip_tc_errs),
    .bip_path_cnt(bip_path_cnt), .bip_tc_cnt(bip_tc_cnt));

  mccr_bus_model i_mccr_bus_model (
    .clk(clk), .rst_n(rst_n), .run(run), .tx_clk(tx_clk), .a_data(a_add_in), .b_data(b_add_in));

  // 25 mhz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict and end of run, reached from the main sequence or the watchdog
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one compare for every kind of result, widened to 16 bits
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // advance n edges, then settle off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle write strobe; ram write strobe is sampled mid-cycle
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr_en = 1'b1;
    #1 last_iwr = iram_wr;
    step(1);
    wr_en = 1'b0;
  endtask

  // one-cycle read strobe, data compared after the answering edge
  task automatic rd(input logic [10:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    #1 addr = a;
    rd_en = 1'b1;
    step(1);
    rd_en = 1'b0;
    chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask

  // one frame result on both bip counters
  task automatic bip(input logic [1:0] p, input logic [1:0] t);
    bip_path_errs = p;
    bip_tc_errs = t;
    bip_valid = 1'b1;
    step(1);
    bip_valid = 1'b0;
    step(1);
  endtask

  // watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    {rst_n, soft_rst, wr_en, rd_en, bts, npi_slot_valid, bip_valid} = 7'h00;
    addr = 11'h000;
    wdata = 8'h00;
    iram_rdata = 8'h3C;
    {npi_tug, npi_byte, bip_path_errs, bip_tc_errs} = 8'h00;
    run = 2'h3;
    npi_exp = '{mccr_pkg::NPI_BYTE0, mccr_pkg::NPI_BYTE1, mccr_pkg::NPI_BYTE2};
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    // reset values and access
    chk("a_oe_rst", 16'h0000, {15'h0, a_add_oe});
    rd(mccr_pkg::ADDR_FMT_CTRL, mccr_pkg::FMT_CTRL_RST, "fmt_rst");
    rd(mccr_pkg::ADDR_TEST_LO, 8'h00, "test_lo");
    rd(mccr_pkg::ADDR_TEST_HI, 8'h00, "test_hi");
    rd(mccr_pkg::ADDR_REPROG, 8'h00, "reprog_rst");
    rd(11'h7FF, 8'h00, "unmapped");
    wr(11'h7FF, 8'hFF);
    wr(mccr_pkg::ADDR_TEST_LO, 8'h00);
    // ram offset assembly and reprogram access
    wr(mccr_pkg::ADDR_OFFS_LO, 8'hA5);
    wr(mccr_pkg::ADDR_REPROG, 8'h85);
    chk("iram_addr", 16'h05A5, {5'h0, iram_addr});
    chk("iram_sw_en", 16'h0001, {15'h0, iram_sw_en});
    rd(mccr_pkg::ADDR_REPROG, 8'h85, "reprog_rd");
    wr(mccr_pkg::ADDR_IRAM_DAT, 8'h5A);
    chk("iram_wr_on", 16'h0001, {15'h0, last_iwr});
    chk("iram_wdata", 16'h005A, {8'h00, iram_wdata});
    rd(mccr_pkg::ADDR_IRAM_DAT, 8'h3C, "iram_rd_on");
    wr(mccr_pkg::ADDR_REPROG, 8'h00);
    wr(mccr_pkg::ADDR_OFFS_LO, 8'h00);
    wr(mccr_pkg::ADDR_IRAM_DAT, 8'h5A);
    chk("iram_wr_off", 16'h0000, {15'h0, last_iwr});
    rd(mccr_pkg::ADDR_IRAM_DAT, 8'h00, "iram_rd_off");
    chk("iram_addr0", 16'h0000, {5'h0, iram_addr});
    // every format code, tristate cleared
    for (int f = 0; f < 4; f++) begin
      wr(mccr_pkg::ADDR_FMT_CTRL, {f[1:0], 6'h00});
      chk("format_sel", 16'(f), {14'h0, format_sel});
      step(1);
      chk("a_oe_on", 16'h0001, {15'h0, a_add_oe});
      chk("b_oe_on", 16'h0001, {15'h0, b_add_oe});
    end
    // each tristate bit floats only its own bus
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h20);
    v = b_add_in;
    step(1);
    chk("a_oe_tri", 16'h0000, {15'h0, a_add_oe});
    chk("b_data", {8'h00, v}, {8'h00, b_add_out});
    chk("b_oe_live", 16'h0001, {15'h0, b_add_oe});
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h10);
    v = a_add_in;
    step(1);
    chk("a_data", {8'h00, v}, {8'h00, a_add_out});
    chk("b_oe_tri", 16'h0000, {15'h0, b_add_oe});
    // software reset floats both buses again
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h00);
    soft_rst = 1'b1;
    step(1);
    soft_rst = 1'b0;
    step(1);
    chk("a_oe_srst", 16'h0000, {15'h0, a_add_oe});
    chk("b_oe_srst", 16'h0000, {15'h0, b_add_oe});
    rd(mccr_pkg::ADDR_FMT_CTRL, 8'h30, "fmt_srst");
    // error pair counted as two, then as one block
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h00);
    bip(2'h2, 2'h1);
    chk("path_cnt2", 16'h0002, bip_path_cnt);
    chk("tc_cnt1", 16'h0001, bip_tc_cnt);
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h08);
    bip(2'h2, 2'h1);
    chk("path_blk", 16'h0003, bip_path_cnt);
    chk("tc_blk", 16'h0002, bip_tc_cnt);
    // null pointer on the first group only, all column-1 positions
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'hC4);
    npi_slot_valid = 1'b1;
    for (int t = 0; t < 3; t++) begin
      for (int b = 0; b < 3; b++) begin
        npi_tug = t[1:0];
        npi_byte = b[1:0];
        step(1);
        chk("npi_a_oe", 16'(t == 0), {15'h0, a_add_oe});
        chk("npi_b_oe", 16'(t == 0), {15'h0, b_add_oe});
        if (t == 0) begin
          chk("npi_byte", {8'h00, npi_exp[b]}, {8'h00, a_add_out});
        end
      end
    end
    // enable bit has no effect outside the tug-3 format
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h84);
    npi_tug = 2'h0;
    step(1);
    chk("npi_au3", 16'h0000, {15'h0, a_add_oe});
    npi_slot_valid = 1'b0;
    // stalled add clock floats the bus; switching to the live clock recovers
    wr(mccr_pkg::ADDR_FMT_CTRL, 8'h00);
    run = 2'h2;
    step(32);
    chk("tx_loc_set", 16'h0001, {15'h0, tx_loc});
    chk("a_oe_loc", 16'h0000, {15'h0, a_add_oe});
    bts = 1'b1;
    step(8);
    chk("tx_loc_clr", 16'h0000, {15'h0, tx_loc});
    chk("a_oe_back", 16'h0001, {15'h0, a_add_oe});
    run = 2'h3;
    close_out();
  end
endmodule

// file: verilog/mccr_bip_count.sv
// saturating bip-2 performance counter with block counting option
`timescale 1ns/1ps
module mccr_bip_count #(
  parameter int CNT_W = 16            // counter width
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             err_valid,  // one frame's result present
  input  wire logic [1:0]       err_count,  // bip-2 errors in it, 0..2
  input  wire logic             block_mode, // count a pair as one block
  output logic      [CNT_W-1:0] count       // accumulated count
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;            // running count
  } mccr_bip_st_t;

  mccr_bip_st_t st_r;                 // registered state
  mccr_bip_st_t st_nxt;               // next state
  logic [CNT_W:0] sum;                // one extra bit to see overflow

  initial begin
    if (CNT_W < 2) $error("counter too narrow");
  end

  // add the frame's contribution, holding at full scale
  always_comb begin
    st_nxt = st_r;
    sum    = {1'b0, st_r.cnt};
    if (err_valid) begin
      // pair counted once in block mode
      if (block_mode) sum = sum + {{CNT_W{1'b0}}, (err_count != 2'h0)};
      else sum = sum + {{(CNT_W - 1){1'b0}}, err_count};
    end
    // saturation keeps a wrapped count from looking small
    st_nxt.cnt = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign count = st_r.cnt;

  a_bip_block_one: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid && block_mode && err_count == mccr_pkg::BIP_PAIR && !(&count)
    |=> count == $past(count) + 1'b1)
    else $error("pair not counted as one block");
  a_bip_pair_two: assert property (@(posedge clk) disable iff (!rst_n)
    err_valid && !block_mode && err_count == mccr_pkg::BIP_PAIR && count < {CNT_W{1'b1}} - 1'b1
    |=> count == $past(count) + 2'h2)
    else $error("pair not counted as two errors");
endmodule

// file: verilog/mccr_npi_gen.sv
// null pointer indicator byte generator for the three tug-3 groups
`timescale 1ns/1ps
module mccr_npi_gen (
  input  wire logic [1:0] fmt,        // format field
  input  wire logic [2:0] npi_sel,    // per tug-3 enables
  input  wire logic       slot_valid, // bus is at a column-1 pointer byte
  input  wire logic [1:0] tug,        // tug-3 index 0..2
  input  wire logic [1:0] byte_idx,   // byte within column 1, 0..2
  output logic            npi_pos,    // this is a pointer byte position
  output logic            npi_drive,  // indicator to be driven here
  output logic [7:0]      npi_value   // indicator byte
);
  // pure decode, the top registers the bus outputs
  always_comb begin
    // first three bytes of column 1
    npi_pos   = slot_valid && (tug <= mccr_pkg::NPI_LAST) && (byte_idx <= mccr_pkg::NPI_LAST);
    npi_drive = npi_pos && (fmt == mccr_pkg::FMT_TUG3) && npi_sel[mccr_pkg::NPI_MSB - tug];
    case (byte_idx)
      2'h0:    npi_value = mccr_pkg::NPI_BYTE0;
      2'h1:    npi_value = mccr_pkg::NPI_BYTE1;
      default: npi_value = mccr_pkg::NPI_BYTE2;
    endcase
  end
endmodule

// file: verilog/mccr_top.sv
// common control and processor load registers of the tributary mapper
`timescale 1ns/1ps
// Behaviour
// - ram offset low eight bits from load register
// - ram offset upper three bits from reprogram
// - reprogram bit opens instruction ram access
// - two format bits select bus format
// - a-side tristate bit floats a add bus
// - b-side tristate bit floats b add bus
// - any reset sets both tristate bits
// - block mode counts error pair once
// - otherwise error pair counts as two
// - null pointer only in tug-3 format
// - indicator in first three column-1 bytes
// - indicator bytes are 93, E0, 00
// - disabled indicator positions stay high impedance
// - lost transmit clock floats the add bus
module mccr_top #(
  parameter int CNT_W = 16                 // bip counter width
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             soft_rst,      // software reset pulse
  // processor port
  input  wire logic [10:0]      addr,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  input  wire logic [7:0]       wdata,
  output logic      [7:0]       rdata,
  // instruction ram of the internal maintenance processor
  output logic                  iram_sw_en,
  output logic      [10:0]      iram_addr,
  output logic                  iram_wr,
  output logic      [7:0]       iram_wdata,
  input  wire logic [7:0]       iram_rdata,
  // format and timing
  output logic      [1:0]       format_sel,
  input  wire logic             bus_timing_select,
  input  wire logic             tx_clk_add,
  input  wire logic             tx_clk_drop,
  output logic                  tx_loc,
  // pointer byte position from the bus timing logic
  input  wire logic             npi_slot_valid,
  input  wire logic [1:0]       npi_tug,
  input  wire logic [1:0]       npi_byte,
  // add bus data paths
  input  wire logic [7:0]       a_add_in,
  input  wire logic [7:0]       b_add_in,
  output logic      [7:0]       a_add_out,
  output logic                  a_add_oe,
  output logic      [7:0]       b_add_out,
  output logic                  b_add_oe,
  // bip-2 results per frame
  input  wire logic             bip_valid,
  input  wire logic [1:0]       bip_path_errs,
  input  wire logic [1:0]       bip_tc_errs,
  output logic      [CNT_W-1:0] bip_path_cnt,
  output logic      [CNT_W-1:0] bip_tc_cnt
);

  // all register state of the block
  typedef struct packed {
    logic [7:0]                 test_lo;   // test register low
    logic [7:0]                 offs_lo;   // instruction ram offset low
    logic [7:0]                 reprog;    // reprogram control
    logic [7:0]                 test_hi;   // test register high
    logic [7:0]                 fmt_ctrl;  // format and bus control
    logic [7:0]                 rdata;     // read data holding
    logic                       txc_prev;  // last transmit clock sample
    logic [mccr_pkg::LOC_CNT_W-1:0] loc_cnt; // cycles since an edge
    logic                       loc;       // transmit clock lost
    logic [7:0]                 a_out;     // a add bus data
    logic                       a_oe;      // a add bus drive
    logic [7:0]                 b_out;     // b add bus data
    logic                       b_oe;      // b add bus drive
  } mccr_st_t;

  mccr_st_t st_r;                          // registered state
  mccr_st_t st_nxt;                        // next state

  logic       npi_pos;                     // pointer byte position now
  logic       npi_drive;                   // indicator enabled here
  logic [7:0] npi_value;                   // indicator byte value
  logic       txc_sel;                     // selected transmit clock

  // the counter must hold the detection window
  initial begin
    if (mccr_pkg::LOC_CYCLES >= (1 << mccr_pkg::LOC_CNT_W)) $error("loc counter too narrow");
    if (CNT_W < 2) $error("bip counter too narrow");
  end

  // drive decision for one add bus byte position
  function automatic logic bus_oe(input logic tri_bit, input logic loc,
                                  input logic pos, input logic drive);
    // a set tristate bit or lost clock floats everything
    if (tri_bit || loc) bus_oe = 1'b0;
    else if (pos) bus_oe = drive;
    // ordinary payload is driven
    else bus_oe = 1'b1;
  endfunction

  // data to present on one add bus byte position
  function automatic logic [7:0] bus_data(input logic pos, input logic [7:0] npi,
                                          input logic [7:0] payload);
    bus_data = pos ? npi : payload;
  endfunction

  // pointer byte decode
  mccr_npi_gen u_npi (
    .fmt        (st_r.fmt_ctrl[mccr_pkg::FMT_HI_BIT:mccr_pkg::FMT_LO_BIT]),
    .npi_sel    (st_r.fmt_ctrl[mccr_pkg::NPI_MSB:0]),
    .slot_valid (npi_slot_valid),
    .tug        (npi_tug),
    .byte_idx   (npi_byte),
    .npi_pos    (npi_pos),
    .npi_drive  (npi_drive),
    .npi_value  (npi_value)
  );

  // path overhead bip-2 counter
  mccr_bip_count #(.CNT_W(CNT_W)) u_bip_path (
    .clk        (clk),
    .rst_n      (rst_n),
    .err_valid  (bip_valid),
    .err_count  (bip_path_errs),
    .block_mode (st_r.fmt_ctrl[mccr_pkg::BLOCK_BIT]),
    .count      (bip_path_cnt)
  );

  // tandem overhead bip-2 counter
  mccr_bip_count #(.CNT_W(CNT_W)) u_bip_tc (
    .clk        (clk),
    .rst_n      (rst_n),
    .err_valid  (bip_valid),
    .err_count  (bip_tc_errs),
    .block_mode (st_r.fmt_ctrl[mccr_pkg::BLOCK_BIT]),
    .count      (bip_tc_cnt)
  );

  // transmit clock chosen by the bus timing select
  assign txc_sel = bus_timing_select ? tx_clk_drop : tx_clk_add;

  // next state of every register
  always_comb begin
    st_nxt = st_r;
    // register writes, decoded by plain address compare
    if (wr_en) begin
      if (addr == mccr_pkg::ADDR_TEST_LO) begin
        // test bits are kept but steer nothing
        st_nxt.test_lo = wdata;
      end else if (addr == mccr_pkg::ADDR_OFFS_LO) begin
        st_nxt.offs_lo = wdata;
      end else if (addr == mccr_pkg::ADDR_REPROG) begin
        st_nxt.reprog = wdata;
      end else if (addr == mccr_pkg::ADDR_TEST_HI) begin
        st_nxt.test_hi = wdata;
      end else if (addr == mccr_pkg::ADDR_FMT_CTRL) begin
        st_nxt.fmt_ctrl = wdata;
      end
    end
    // software reset wins over a same-cycle write
    if (soft_rst) begin
      st_nxt.fmt_ctrl[mccr_pkg::A_TRI_BIT] = 1'b1;
      st_nxt.fmt_ctrl[mccr_pkg::B_TRI_BIT] = 1'b1;
    end
    // read data, captured one edge after the strobe
    if (rd_en) begin
      if (addr == mccr_pkg::ADDR_TEST_LO) begin
        st_nxt.rdata = st_r.test_lo;
      end else if (addr == mccr_pkg::ADDR_OFFS_LO) begin
        st_nxt.rdata = st_r.offs_lo;
      end else if (addr == mccr_pkg::ADDR_REPROG) begin
        st_nxt.rdata = st_r.reprog;
      end else if (addr == mccr_pkg::ADDR_TEST_HI) begin
        st_nxt.rdata = st_r.test_hi;
      end else if (addr == mccr_pkg::ADDR_FMT_CTRL) begin
        st_nxt.rdata = st_r.fmt_ctrl;
      end else if (addr == mccr_pkg::ADDR_IRAM_DAT && iram_sw_en) begin
        // ram contents only visible while reprogramming
        st_nxt.rdata = iram_rdata;
      end else begin
        // unmapped or gated reads return zero
        st_nxt.rdata = mccr_pkg::RDATA_RST;
      end
    end
    // edge watch on the chosen transmit clock
    st_nxt.txc_prev = txc_sel;
    if (txc_sel != st_r.txc_prev) begin
      // any edge restarts the window and clears the alarm
      st_nxt.loc_cnt = '0;
      st_nxt.loc     = 1'b0;
    end else if (st_r.loc_cnt >= mccr_pkg::LOC_CNT_W'(mccr_pkg::LOC_CYCLES)) begin
      // window expired, clock considered gone
      st_nxt.loc = 1'b1;
    end else begin
      st_nxt.loc_cnt = st_r.loc_cnt + 1'b1;
    end
    // a bus drive from its tristate bit
    st_nxt.a_oe  = bus_oe(st_r.fmt_ctrl[mccr_pkg::A_TRI_BIT], st_r.loc, npi_pos, npi_drive);
    // b bus drive from its tristate bit
    st_nxt.b_oe  = bus_oe(st_r.fmt_ctrl[mccr_pkg::B_TRI_BIT], st_r.loc, npi_pos, npi_drive);
    st_nxt.a_out = bus_data(npi_pos, npi_value, a_add_in);
    st_nxt.b_out = bus_data(npi_pos, npi_value, b_add_in);
  end

  // one register stage for all state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      // hardware reset floats both add buses
      st_r.fmt_ctrl <= mccr_pkg::FMT_CTRL_RST;
      st_r.test_lo  <= mccr_pkg::TEST_RST;
      st_r.test_hi  <= mccr_pkg::TEST_RST;
      st_r.offs_lo  <= mccr_pkg::OFFS_LO_RST;
      st_r.reprog   <= mccr_pkg::REPROG_RST;
      st_r.rdata    <= mccr_pkg::RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // low eight offset bits from load register
  assign iram_addr[7:0]  = st_r.offs_lo;
  // upper three offset bits from reprogram
  assign iram_addr[10:8] = st_r.reprog[mccr_pkg::OFFS_HI_MSB:0];
  // ram window open while reprogram set
  assign iram_sw_en      = st_r.reprog[mccr_pkg::REPROG_BIT];
  // a data write is passed through only inside the window
  assign iram_wr         = wr_en && (addr == mccr_pkg::ADDR_IRAM_DAT) && iram_sw_en;
  assign iram_wdata      = wdata;

  // format field straight to the bus logic
  assign format_sel = st_r.fmt_ctrl[mccr_pkg::FMT_HI_BIT:mccr_pkg::FMT_LO_BIT];
  assign tx_loc     = st_r.loc;
  assign rdata      = st_r.rdata;
  assign a_add_out  = st_r.a_out;
  assign a_add_oe   = st_r.a_oe;
  assign b_add_out  = st_r.b_out;
  assign b_add_oe   = st_r.b_oe;

  // checks run on the block clock, quiet under reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // software reset sets the bits, then the buses float
  sequence s_soft_rst;
    soft_rst ##1 (st_r.fmt_ctrl[mccr_pkg::A_TRI_BIT] && st_r.fmt_ctrl[mccr_pkg::B_TRI_BIT]);
  endsequence

  a_soft_rst_float: assert property (s_soft_rst |=> !a_add_oe && !b_add_oe)
    else $error("add bus driven after software reset");
  a_offs_low_load: assert property (wr_en && addr == mccr_pkg::ADDR_OFFS_LO
    |=> iram_addr[7:0] == $past(wdata))
    else $error("offset low bits not loaded");
  a_offs_high_load: assert property (wr_en && addr == mccr_pkg::ADDR_REPROG
    |=> iram_addr[10:8] == $past(wdata[2:0]) && iram_sw_en == $past(wdata[7]))
    else $error("offset high bits or window not loaded");
  a_iram_gate: assert property (wr_en && addr == mccr_pkg::ADDR_IRAM_DAT
    |-> iram_wr == st_r.reprog[mccr_pkg::REPROG_BIT])
    else $error("ram write not gated by reprogram bit");
  a_format_write: assert property (wr_en && addr == mccr_pkg::ADDR_FMT_CTRL && !soft_rst
    |=> format_sel == $past(wdata[7:6]) && st_r.fmt_ctrl[mccr_pkg::A_TRI_BIT] == $past(wdata[5]))
    else $error("format field not applied");
  a_a_side_float: assert property (st_r.fmt_ctrl[mccr_pkg::A_TRI_BIT] |=> !a_add_oe)
    else $error("a add bus driven while tristated");
  a_b_side_float: assert property (st_r.fmt_ctrl[mccr_pkg::B_TRI_BIT] |=> !b_add_oe)
    else $error("b add bus driven while tristated");
  a_loc_float: assert property (tx_loc |=> !a_add_oe && !b_add_oe)
    else $error("add bus driven without transmit clock");
  a_loc_detect: assert property ($stable(txc_sel) && st_r.loc_cnt == 6'd25 |=> tx_loc)
    else $error("lost clock not flagged");
  a_npi_value: assert property (npi_pos && npi_drive && !st_r.loc
    && !st_r.fmt_ctrl[mccr_pkg::A_TRI_BIT] |=> a_add_oe && a_add_out == $past(npi_value))
    else $error("indicator byte not driven");
  a_npi_float: assert property (npi_pos && !npi_drive |=> !a_add_oe && !b_add_oe)
    else $error("disabled indicator position driven");
  a_npi_format: assert property (npi_drive |-> format_sel == mccr_pkg::FMT_TUG3)
    else $error("indicator outside tug-3 format");
endmodule
